// ==== ttx_pkg.sv ====
// constants, carriers and state codes shared by the tone transceiver port
package ttx_pkg;

	// ==========================================================
	// clocking and timing
	localparam int CORE_HZ = 20_000_000; // core clock rate
	localparam int CORE_NS = 50; // core clock period in ns
	localparam int REF_HZ = 3_579_545; // tone reference rate
	localparam int SETTLE_NS = 500; // output latch settling time
	localparam int SETTLE_CYC = (SETTLE_NS + CORE_NS - 1) / CORE_NS;
	localparam int BURST_MS = 51; // tone burst length
	localparam int PAUSE_MS = 51; // pause after a burst
	localparam int BURST_TICKS_DEF = BURST_MS * REF_HZ / 1000;
	localparam int PAUSE_TICKS_DEF = PAUSE_MS * REF_HZ / 1000;
	localparam int ACC_W = 25; // phase accumulator width
	localparam logic [24:0] ACC_MOD = 25'(CORE_HZ); // wrap value
	localparam logic [24:0] ACC_INC = 25'(REF_HZ); // step per cycle
	localparam int BCNT_W = 18; // burst counter width
	localparam logic [3:0] SETTLE_LOAD = 4'(SETTLE_CYC - 1);
	localparam logic [1:0] PUB_HOLD = 2'h3; // cycles a read word holds after its publish cycle

	// ==========================================================
	// register select and field positions
	localparam logic RS_DATA = 1'b0; // data registers
	localparam logic RS_CTRL = 1'b1; // status or control registers
	localparam int CA_TONE_EN = 0; // control a: tone output enable
	localparam int CA_CP_MODE = 1; // control a: call progress mode
	localparam int CA_IRQ_EN = 2; // control a: interrupt enable
	localparam int CA_SEL_B = 3; // control a: next control write goes to b
	localparam int CB_BURST = 0; // control b: burst mode
	localparam int ST_IRQ = 0; // status: interrupt pending
	localparam int ST_TX_RDY = 1; // status: transmitter ready
	localparam int ST_DSTEER = 2; // status: delayed steering
	localparam int ST_EST = 3; // status: early tone valid
	localparam logic [3:0] CTRL_RST = 4'h0; // control reset value
	localparam logic [3:0] DATA_RST = 4'h0; // data reset value

	// ==========================================================
	// carriers and states
	typedef struct packed {
		logic rs; // register select of the write
		logic [3:0] data; // written nibble
	} ttx_wr_t;

	typedef struct packed {
		logic [3:0] status; // status register image
		logic [3:0] rx; // receive data register image
	} ttx_rdw_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_BURST = 2'b01,
		TX_PAUSE = 2'b10
	} ttx_tx_state_t;

endpackage

// ==== ttx_sync2.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ttx_sync2 import ttx_pkg::*; #(
	parameter int W = 1 // number of bits
) (
	input wire logic clk, // destination clock
	input wire logic [W-1:0] d, // asynchronous level in
	output var logic [W-1:0] q // synchronised level out
);
	logic [W-1:0] meta_q; // first stage, read only by the second

	// ==========================================================
	// two stages, no reset so no constant is forced into them
	always_ff @(posedge clk) begin
		meta_q <= d;
		q <= meta_q;
	end
endmodule
`default_nettype wire

// ==== ttx_bus_side.sv ====
// host bus logic clocked by the bus clock phase
`timescale 1ns/1ps
`default_nettype none
module ttx_bus_side import ttx_pkg::*; (
	input wire logic bus_clk, // bus clock phase, may stop
	input wire logic rstn, // core reset, synchronised here
	input wire logic bus_cs_n, // chip select, low active
	input wire logic bus_rw, // 1 read, 0 write
	input wire logic rs, // register select
	input wire logic [3:0] din, // data from host
	input wire ttx_rdw_t rd_word, // read image, held between changes
	output var ttx_wr_t wr_word, // last write, held
	output var logic wr_tgl, // toggles on each write
	output var logic [3:0] dout, // read data
	output var logic drv_q, // drive marker, high phase
	output var logic rel_q // release marker, low phase
);
	logic lrst_n; // reset in bus clock domain

	ttx_sync2 #(.W(1)) u_sync (
		.clk(bus_clk),
		.d(rstn),
		.q(lrst_n)
	);

	// ==========================================================
	// read: start driving at the rising phase edge when selected
	// the word is taken straight from the held core image, since the
	// phase clock may have stood still since the last change
	always_ff @(posedge bus_clk) begin
		if (!lrst_n) begin
			drv_q <= 1'b0;
			dout <= DATA_RST;
		end else if (!bus_cs_n && bus_rw) begin
			drv_q <= ~rel_q;
			dout <= (rs == RS_CTRL) ? rd_word.status : rd_word.rx;
		end
	end

	// release at the falling phase edge, so low phase is high-z
	always_ff @(negedge bus_clk) begin
		if (!lrst_n) begin
			rel_q <= 1'b0;
		end else begin
			rel_q <= drv_q;
		end
	end

	// ==========================================================
	// write: capture at the falling phase edge
	always_ff @(negedge bus_clk) begin
		if (!lrst_n) begin
			wr_word <= '0;
			wr_tgl <= 1'b0;
		end else if (!bus_cs_n && !bus_rw) begin
			wr_word <= '{rs: rs, data: din};
			wr_tgl <= ~wr_tgl;
		end
	end

	// ==========================================================
	// checks in the bus clock domain
	a_bus_released: assert property (@(posedge bus_clk)
		disable iff (!rstn || !lrst_n) drv_q == rel_q)
		else $error("data bus still driven at start of high phase");
	a_wr_captured: assert property (@(negedge bus_clk)
		disable iff (!rstn || !lrst_n) (!bus_cs_n && !bus_rw)
		|=> wr_word.data == $past(din) && wr_tgl != $past(wr_tgl))
		else $error("write data not captured at falling edge");
	c_bus_read: cover property (@(posedge bus_clk)
		disable iff (!lrst_n) !bus_cs_n && bus_rw);
endmodule
`default_nettype wire

// ==== ttx_host_port.sv ====
// tone transceiver host port, steering and transmit timing
`timescale 1ns/1ps
`default_nettype none
module ttx_host_port import ttx_pkg::*; #(
	parameter int BURST_TICKS = BURST_TICKS_DEF, // burst, reference ticks
	parameter int PAUSE_TICKS = PAUSE_TICKS_DEF // pause, reference ticks
) (
	input wire logic core_clk, // core clock, 20 mhz
	input wire logic rstn, // synchronous reset, low active
	input wire logic bus_clk, // bus clock phase from host
	input wire logic bus_cs_n, // chip select, low active
	input wire logic bus_rw, // 1 read, 0 write
	input wire logic register_select_bit, // register select
	input wire logic [3:0] host_data_nibble_in, // data bus in
	output var logic [3:0] host_data_nibble_out, // data bus out
	output var logic host_data_nibble_oe_n, // low while driving
	input wire logic tone_valid_in, // detector sees valid pair
	input wire logic [3:0] tone_code_in, // detector pair code
	input wire logic progress_band_in, // in-band comparator, pin
	input wire logic steering_sense_in, // steering above threshold
	output var logic early_tone_valid, // early valid output
	output var logic guard_drive_out, // guard level
	output var logic guard_drive_oe_n, // low while guard drives
	output var logic interrupt_or_progress_out, // always low
	output var logic interrupt_or_progress_oe_n, // low pulls pin
	output var logic [3:0] tone_code_out, // code to generator
	output var logic tone_burst_on, // generator enable
	output var logic progress_tone_mode // progress mode selected
);
	localparam int SETTLE_N = SETTLE_CYC; // settle cycles

	// ==========================================================
	// declarations
	logic st_s; // synchronised steering sense
	logic band_s; // synchronised in-band comparator
	logic wr_tgl; // write toggle, bus clock domain
	logic wr_tgl_s; // write toggle, synchronised
	logic wr_prev_q; // previous write toggle
	logic wr_p; // one core cycle per host write
	ttx_wr_t wr_word; // held write word
	logic [3:0] bus_dout; // read data from bus side
	logic bus_drv; // drive marker from bus side
	logic bus_rel; // release marker from bus side
	logic [3:0] ctrl_a_q; // control register a
	logic [3:0] ctrl_b_q; // control register b
	logic sel_b_q; // next control write goes to b
	logic [3:0] tx_code_q; // transmit data register
	logic [3:0] rx_q; // receive data register
	logic [ACC_W-1:0] acc_q; // reference phase accumulator
	logic ref_tick_q; // one pulse per reference period
	logic armed_q; // ready to register a new pair
	logic latch_p; // registration moment
	logic settle_run_q; // settle timer running
	logic [3:0] settle_cnt_q; // settle timer count
	logic dsteer_q; // delayed steering flag
	logic tx_rdy_q; // transmitter ready
	ttx_tx_state_t tx_st_q; // burst sequencer state
	logic [BCNT_W-1:0] bcnt_q; // burst or pause counter
	ttx_rdw_t rdw_q; // published read image
	ttx_rdw_t rdw_d; // read image to publish
	logic [1:0] pub_hold_q; // hold time of a published image
	logic cp_mode; // progress mode bit
	logic irq_en; // interrupt enable bit

	assign cp_mode = ctrl_a_q[CA_CP_MODE];
	assign irq_en = ctrl_a_q[CA_IRQ_EN];

	// pending interrupt for the status image; the pin decodes the same terms outside progress mode and follows band_s in progress mode if irq_en
	function automatic logic irq_pending(input logic [3:0] ca,
		input logic ds);
		irq_pending = ca[CA_IRQ_EN] && !ca[CA_CP_MODE] && ds;
	endfunction

	// ==========================================================
	// bus side and crossings
	ttx_bus_side u_bus (
		.bus_clk(bus_clk),
		.rstn(rstn),
		.bus_cs_n(bus_cs_n),
		.bus_rw(bus_rw),
		.rs(register_select_bit),
		.din(host_data_nibble_in),
		.rd_word(rdw_q),
		.wr_word(wr_word),
		.wr_tgl(wr_tgl),
		.dout(bus_dout),
		.drv_q(bus_drv),
		.rel_q(bus_rel)
	);

	// steering and band pins and the write toggle enter the core through two stages
	ttx_sync2 #(.W(3)) u_sync (
		.clk(core_clk),
		.d({steering_sense_in, progress_band_in, wr_tgl}),
		.q({st_s, band_s, wr_tgl_s})
	);

	// drive marker pair is only defined within the high phase
	assign host_data_nibble_out = bus_dout;
	assign host_data_nibble_oe_n = ~(bus_drv ^ bus_rel);

	// write event: the held word is stable long before the toggle
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_prev_q <= 1'b0;
		end else begin
			wr_prev_q <= wr_tgl_s;
		end
	end
	assign wr_p = wr_tgl_s ^ wr_prev_q;

	// ==========================================================
	// register writes: data write to transmit, control a then b
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ctrl_a_q <= CTRL_RST;
			ctrl_b_q <= CTRL_RST;
			sel_b_q <= 1'b0;
			tx_code_q <= DATA_RST;
		end else if (wr_p) begin
			if (wr_word.rs == RS_DATA) begin
				tx_code_q <= wr_word.data;
			end else if (sel_b_q) begin
				ctrl_b_q <= wr_word.data;
				sel_b_q <= 1'b0;
			end else begin
				ctrl_a_q <= wr_word.data;
				sel_b_q <= wr_word.data[CA_SEL_B];
			end
		end
	end

	// ==========================================================
	// reference tick at the tone reference rate
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			acc_q <= '0;
			ref_tick_q <= 1'b0;
		end else if (acc_q + ACC_INC >= ACC_MOD) begin
			acc_q <= ACC_W'(acc_q + ACC_INC - ACC_MOD);
			ref_tick_q <= 1'b1;
		end else begin
			acc_q <= ACC_W'(acc_q + ACC_INC);
			ref_tick_q <= 1'b0;
		end
	end

	// ==========================================================
	// early valid, blocked in progress mode
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			early_tone_valid <= 1'b0;
		end else begin
			early_tone_valid <= tone_valid_in && !cp_mode;
		end
	end

	// ==========================================================
	// steering: register on threshold crossing, re-arm below it
	assign latch_p = st_s && armed_q && !cp_mode;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			armed_q <= 1'b1;
			rx_q <= DATA_RST;
		end else if (latch_p) begin
			armed_q <= 1'b0;
			rx_q <= tone_code_in;
		end else if (!st_s) begin
			armed_q <= 1'b1;
		end
	end

	// delayed steering after the latch has settled
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			settle_run_q <= 1'b0;
			settle_cnt_q <= '0;
			dsteer_q <= 1'b0;
		end else if (latch_p) begin
			settle_run_q <= 1'b1;
			settle_cnt_q <= SETTLE_LOAD;
		end else if (!st_s) begin
			settle_run_q <= 1'b0;
			dsteer_q <= 1'b0;
		end else if (settle_run_q) begin
			if (settle_cnt_q == '0) begin
				settle_run_q <= 1'b0;
				dsteer_q <= 1'b1;
			end else begin
				settle_cnt_q <= settle_cnt_q - 4'h1;
			end
		end
	end

	// guard drives when early valid and steering agree
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			guard_drive_out <= 1'b0;
			guard_drive_oe_n <= 1'b1;
		end else begin
			guard_drive_out <= early_tone_valid;
			guard_drive_oe_n <= early_tone_valid != st_s;
		end
	end

	// ==========================================================
	// interrupt pin: open drain, flag or progress square wave
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			interrupt_or_progress_out <= 1'b0;
			interrupt_or_progress_oe_n <= 1'b1;
		end else begin
			interrupt_or_progress_out <= 1'b0;
			if (!irq_en) begin
				interrupt_or_progress_oe_n <= 1'b1;
			end else if (cp_mode) begin
				interrupt_or_progress_oe_n <= band_s;
			end else begin
				interrupt_or_progress_oe_n <= !dsteer_q;
			end
		end
	end

	// ==========================================================
	// transmit: plain tone enable or timed burst and pause
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tx_st_q <= TX_IDLE;
			bcnt_q <= '0;
			tone_burst_on <= 1'b0;
			tx_rdy_q <= 1'b1;
		end else begin
			case (tx_st_q)
				TX_IDLE: begin
					if (wr_p && wr_word.rs == RS_DATA
						&& ctrl_b_q[CB_BURST]) begin
						tx_st_q <= TX_BURST;
						bcnt_q <= BCNT_W'(BURST_TICKS - 1);
						tone_burst_on <= 1'b1;
						tx_rdy_q <= 1'b0;
					end else begin
						tone_burst_on <= ctrl_a_q[CA_TONE_EN]
							&& !ctrl_b_q[CB_BURST];
					end
				end
				TX_BURST: begin
					if (ref_tick_q && bcnt_q == '0) begin
						tx_st_q <= TX_PAUSE;
						bcnt_q <= BCNT_W'(PAUSE_TICKS - 1);
						tone_burst_on <= 1'b0;
					end else if (ref_tick_q) begin
						bcnt_q <= bcnt_q - 1'b1;
					end
				end
				TX_PAUSE: begin
					if (ref_tick_q && bcnt_q == '0) begin
						tx_st_q <= TX_IDLE;
						tx_rdy_q <= 1'b1;
					end else if (ref_tick_q) begin
						bcnt_q <= bcnt_q - 1'b1;
					end
				end
				default: begin
					tx_st_q <= TX_IDLE;
					tone_burst_on <= 1'b0;
					tx_rdy_q <= 1'b1;
				end
			endcase
		end
	end

	// code and mode outputs
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tone_code_out <= DATA_RST;
			progress_tone_mode <= 1'b0;
		end else begin
			tone_code_out <= tx_code_q;
			progress_tone_mode <= cp_mode;
		end
	end

	// ==========================================================
	// read image: changes at most once per four core cycles, so a bus
	// read edge that may come after a long clock stop sees a settled word
	always_comb begin
		rdw_d.rx = rx_q;
		rdw_d.status = '0;
		rdw_d.status[ST_IRQ] = irq_pending(ctrl_a_q, dsteer_q);
		rdw_d.status[ST_TX_RDY] = tx_rdy_q;
		rdw_d.status[ST_DSTEER] = dsteer_q;
		rdw_d.status[ST_EST] = early_tone_valid;
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rdw_q <= '0;
			pub_hold_q <= '0;
		end else if (pub_hold_q != '0) begin
			pub_hold_q <= pub_hold_q - 2'h1;
		end else if (rdw_d != rdw_q) begin
			rdw_q <= rdw_d;
			pub_hold_q <= PUB_HOLD;
		end
	end

	// ==========================================================
	// checks in the core domain
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_est_blocked: assert property (cp_mode |=> !early_tone_valid)
		else $error("early valid raised in progress mode");
	a_est_follows: assert property (!tone_valid_in |=> !early_tone_valid
		##1 !guard_drive_out)
		else $error("early valid or guard held after loss");
	a_est_rises: assert property ((tone_valid_in && !cp_mode)
		|=> early_tone_valid)
		else $error("early valid missed a valid pair");
	a_rx_latched: assert property (latch_p |=> rx_q == $past(tone_code_in)
		&& !armed_q)
		else $error("pair code not registered on steering");
	// helper: cycles since the latch while steering stays high
	logic [3:0] chk_cnt_q; // 1 in the cycle after the latch, saturates
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			chk_cnt_q <= '0;
		end else if (latch_p || !st_s) begin
			chk_cnt_q <= {3'h0, latch_p};
		end else if (chk_cnt_q != '0 && chk_cnt_q != '1) begin
			chk_cnt_q <= chk_cnt_q + 4'h1;
		end
	end

	a_settle_wait: assert property ((chk_cnt_q != '0
		&& chk_cnt_q <= 4'(SETTLE_N)) |-> !dsteer_q)
		else $error("delayed steering rose before settling");
	a_settle_done: assert property ((chk_cnt_q == 4'(SETTLE_N) && st_s)
		|=> dsteer_q)
		else $error("delayed steering missing after settling");
	a_rearm_low: assert property (!st_s && !latch_p
		|=> armed_q && !dsteer_q)
		else $error("receiver not re-armed below threshold");
	a_guard_level: assert property ((early_tone_valid == st_s)
		|=> !guard_drive_oe_n && guard_drive_out == $past(st_s))
		else $error("guard not driving its agreed level");
	a_irq_od: assert property (!interrupt_or_progress_oe_n
		|-> !interrupt_or_progress_out && $past(irq_en))
		else $error("interrupt pin driven without pull-low");
	a_irq_flag: assert property ((irq_en && !cp_mode && dsteer_q)
		|=> !interrupt_or_progress_oe_n)
		else $error("interrupt not pulled with flag active");
	a_cp_wave: assert property ((irq_en && cp_mode)
		|=> interrupt_or_progress_oe_n == $past(band_s))
		else $error("progress wave not on interrupt pin");
	a_ref_rate: assert property (ref_tick_q |=> (!ref_tick_q)[*4])
		else $error("reference tick faster than reference rate");
	a_burst_hold: assert property ((tx_st_q == TX_BURST && bcnt_q != '0)
		|=> tone_burst_on)
		else $error("tone dropped during burst");

	c_register: cover property (latch_p ##[1:40] dsteer_q);
	c_progress: cover property (irq_en && cp_mode && $fell(band_s));
	c_burst: cover property (tx_st_q == TX_BURST ##1 tx_st_q == TX_PAUSE);
	c_write: cover property (wr_p && wr_word.rs == RS_CTRL);
endmodule
`default_nettype wire

// ==== ttx_host_model.sv ====
// host processor model: gated phase clock and nibble bus cycles
`timescale 1ns/1ps
`default_nettype none
module ttx_host_model import ttx_pkg::*; (
	output var logic bus_clk, // phase clock, still between accesses
	output var logic bus_cs_n, // chip select, low active
	output var logic bus_rw, // 1 read, 0 write
	output var logic rs, // register select
	output var logic [3:0] d_wire, // resolved data wire
	input wire logic [3:0] dev_d, // device read data
	input wire logic dev_oe_n // device drives when low
);
	logic [3:0] drv; // host drive value
	logic host_en; // host drives the wire
	// resolve the wire; a released wire shows the inverse of the last value
	always_comb begin
		if (!dev_oe_n) begin
			d_wire = dev_d;
		end else if (host_en) begin
			d_wire = drv;
		end else begin
			d_wire = ~drv;
		end
	end
	// idle bus at time zero, phase clock stopped low
	initial begin
		bus_clk = 1'b0;
		bus_cs_n = 1'b1;
		bus_rw = 1'b1;
		rs = 1'b0;
		drv = 4'h0;
		host_en = 1'b0;
	end
	// deselected phase pulses, used while reset is held and again just after its release
	task automatic idle(input int n);
		repeat (n) begin
			#6 bus_clk = 1'b1;
			#6 bus_clk = 1'b0;
		end
	endtask
	// one access: set up in low phase, sample late in high phase
	task automatic cycle(input logic cs, wr, r, input logic [3:0] v,
		output logic [3:0] q, output logic rel);
		bus_cs_n = cs;
		bus_rw = ~wr; // direction
		rs = r; // register choice
		drv = v;
		host_en = wr & !cs;
		#6 bus_clk = 1'b1;
		#5 q = d_wire;
		#1 bus_clk = 1'b0; // write taken at fall
		#1 rel = dev_oe_n;
		#5 bus_cs_n = 1'b1;
		host_en = 1'b0;
		bus_rw = 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== tb_ttx_host_port.sv ====
// self-checking bench for the tone transceiver host port
`timescale 1ns/1ps
`default_nettype none
module tb_ttx_host_port import ttx_pkg::*; ;
	localparam int BT = 20; // shortened burst and pause ticks
	logic core_clk, rstn, tv, band, steer; // core side stimulus
	logic bus_clk, cs_n, rw, rs, d_oe_n; // bus wires
	logic early, g_out, g_oe_n, i_out, i_oe_n, burst_on, cp_mode;
	logic [3:0] d, dout, code, tx_code; // nibbles
	int errors = 0; // mismatches
	int num_checks = 0; // comparisons
	ttx_host_model host_i (.bus_clk(bus_clk), .bus_cs_n(cs_n),
		.bus_rw(rw), .rs(rs), .d_wire(d), .dev_d(dout),
		.dev_oe_n(d_oe_n));
	ttx_host_port #(.BURST_TICKS(BT), .PAUSE_TICKS(BT)) ttx_host_port_i (
		.core_clk(core_clk), .rstn(rstn), .bus_clk(bus_clk),
		.bus_cs_n(cs_n), .bus_rw(rw), .register_select_bit(rs),
		.host_data_nibble_in(d), .host_data_nibble_out(dout),
		.host_data_nibble_oe_n(d_oe_n), .tone_valid_in(tv),
		.tone_code_in(code), .progress_band_in(band),
		.steering_sense_in(steer), .early_tone_valid(early),
		.guard_drive_out(g_out), .guard_drive_oe_n(g_oe_n),
		.interrupt_or_progress_out(i_out),
		.interrupt_or_progress_oe_n(i_oe_n), .tone_code_out(tx_code),
		.tone_burst_on(burst_on), .progress_tone_mode(cp_mode));
	// 20 mhz core clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic check(input logic [3:0] seen, exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic wait_core(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// bus write, then room for the crossing
	task automatic wr(input logic r, input logic [3:0] v);
		logic [3:0] q;
		logic rel;
		host_i.cycle(1'b0, 1'b1, r, v, q, rel);
		check(rel, 1'b1, "bus held after write"); // released
		wait_core(10);
	endtask
	task automatic rd(input logic r, output logic [3:0] q);
		logic rel;
		host_i.cycle(1'b0, 1'b0, r, 4'h0, q, rel);
		check(rel, 1'b1, "bus held after read"); // low phase
		wait_core(4);
	endtask
	// control and data writes, deselected access ignored
	task automatic t_regs();
		logic [3:0] q;
		logic rel;
		wr(RS_CTRL, 4'h1);
		check(burst_on, 1'b1, "tone enable"); // control a
		wr(RS_DATA, 4'h7);
		check(tx_code, 4'h7, "tx code"); // data register
		host_i.cycle(1'b1, 1'b1, RS_DATA, 4'h2, q, rel);
		wait_core(10);
		check(tx_code, 4'h7, "deselected write"); // ignored
		host_i.cycle(1'b1, 1'b0, RS_CTRL, 4'h0, q, rel);
		check(rel, 1'b1, "deselected read drove"); // high-z
		wr(RS_CTRL, 4'h0);
		check(burst_on, 1'b0, "tone off"); // control a
		$display("regs test done");
	endtask
	// early valid, guard, registration, interrupt, re-arm
	task automatic t_steer();
		logic [3:0] q;
		wr(RS_CTRL, 4'h4);
		@(posedge core_clk) tv <= 1'b1;
		code <= 4'h5;
		wait_core(3);
		check(early, 1'b1, "early rise"); // valid pair
		check(g_oe_n, 1'b1, "guard idle"); // released
		@(posedge core_clk) steer <= 1'b1;
		wait_core(6);
		check(i_oe_n, 1'b1, "flag early"); // settling
		wait_core(14);
		check(i_oe_n, 1'b0, "irq low"); // flag pulls
		check(i_out, 1'b0, "irq high"); // pull only
		check(~g_oe_n & g_out, 1'b1, "guard hold"); // drives high
		code <= 4'h9;
		wait_core(8);
		rd(RS_DATA, q);
		check(q, 4'h5, "rx code"); // one latch
		rd(RS_CTRL, q);
		check(q[ST_DSTEER], 1'b1, "status flag"); // readable
		@(posedge core_clk) tv <= 1'b0;
		@(posedge core_clk) tv <= 1'b1;
		#1 check(early, 1'b0, "dropout"); // loss
		steer <= 1'b0;
		wait_core(10);
		check(i_oe_n, 1'b1, "flag stuck"); // re-armed
		@(posedge core_clk) steer <= 1'b1;
		wait_core(30);
		rd(RS_DATA, q);
		check(q, 4'h9, "new code"); // accepts
		@(posedge core_clk) steer <= 1'b0;
		tv <= 1'b0;
		wait_core(10);
		$display("steer test done");
	endtask
	// call progress: square wave on interrupt, no detection
	task automatic t_cp();
		wr(RS_CTRL, 4'h6);
		check(cp_mode, 1'b1, "mode"); // progress
		@(posedge core_clk) band <= 1'b0;
		wait_core(5);
		check(i_oe_n, 1'b0, "band low"); // follows
		@(posedge core_clk) band <= 1'b1;
		tv <= 1'b1;
		wait_core(5);
		check(i_oe_n, 1'b1, "band high"); // follows
		check(early, 1'b0, "detect in cp"); // blocked
		@(posedge core_clk) tv <= 1'b0;
		wr(RS_CTRL, 4'h0);
		$display("cp test done");
	endtask
	// burst mode: timed burst, pause, then ready
	task automatic t_burst();
		logic [3:0] q;
		logic rel;
		int n;
		int e;
		n = 0;
		e = BT * (CORE_HZ / 1000) / (REF_HZ / 1000);
		wr(RS_CTRL, 4'h8);
		wr(RS_CTRL, 4'h1);
		host_i.cycle(1'b0, 1'b1, RS_DATA, 4'h3, q, rel);
		repeat (300) begin
			@(posedge core_clk);
			n += int'(burst_on);
		end
		check(4'(n >= e - 6 && n <= e + 6), 4'h1, "burst len");
		check(tx_code, 4'h3, "burst code"); // timed burst
		rd(RS_CTRL, q);
		check(q[ST_TX_RDY], 1'b1, "ready"); // after pause
		$display("burst test done");
	endtask
	// watchdog
	initial begin
		#2_000_000;
		errors++;
		complete_run();
	end
	initial begin
		rstn = 1'b0;
		tv = 1'b0;
		band = 1'b1;
		steer = 1'b0;
		code = 4'h0;
		fork
			wait_core(5);
			host_i.idle(4);
		join
		rstn <= 1'b1;
		host_i.idle(4);
		wait_core(4);
		check(d_oe_n & ~g_oe_n & i_oe_n, 1'b1, "reset drive");
		t_regs();
		t_steer();
		t_cp();
		t_burst();
		complete_run();
	end
endmodule
`default_nettype wire
